/* File: scrb_consts.vh */
// Constants for the stepper control register bank
`ifndef SCRB_CONSTS_VH
`define SCRB_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses (bank bit in front of the 4-bit nibble)
// ----------------------------------------------------------------
`define SCRB_ADDR_POL 5'h01
`define SCRB_ADDR_COIL 5'h02
`define SCRB_ADDR_MODE 5'h03
`define SCRB_ADDR_STALL 5'h04
`define SCRB_ADDR_SPEED 5'h05
`define SCRB_ADDR_UVLVL 5'h06
`define SCRB_ADDR_BANK 5'h07
`define SCRB_ADDR_BOOST 5'h14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCRB_RST_POL 8'h00
`define SCRB_RST_COIL 8'h00
`define SCRB_RST_MODE 8'h20
`define SCRB_RST_STALL 8'h10
`define SCRB_RST_SPEED 8'h00
`define SCRB_RST_UVLVL 8'h00
`define SCRB_RST_BANK 8'h00
`define SCRB_RST_BOOST 8'h04
`define SCRB_BOOST_MASK 8'h1F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCRB_DINV_BIT 7
`define SCRB_RHBP_BIT 6
`define SCRB_STEP_BIT 5
`define SCRB_MOTEN_BIT 4
`define SCRB_ENH_BIT 7
`define SCRB_DIAG_BIT 6
`define SCRB_SLEEP_BIT 3
`define SCRB_BANK_BIT 7
`define SCRB_GAIN_BIT 6
`define SCRB_BOOST_BIT 4
`define SCRB_KEEP_BIT 1
`define SCRB_HIZ_BIT 0

// ----------------------------------------------------------------
// Framing and timing
// ----------------------------------------------------------------
`define SCRB_FRAME_BITS 5'd16
`define SCRB_CLK_NS 5
`define SCRB_TICK_NS 1000

`endif

/* File: scrb_sync.v */
// Two-stage synchroniser for pins from outside the clock domain
module scrb_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Pins and synchronised copies
	input wire [W-1:0] async_i,
	output reg [W-1:0] sync_o
);

	reg [W-1:0] meta;

	// First stage read only by second stage
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta <= RST_VAL;
			sync_o <= RST_VAL;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end

endmodule

/* File: scrb_spi.v */
// Oversampled serial slave shifter for 16-bit frames
`include "scrb_consts.vh"

module scrb_spi (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Synchronised serial pins
	input wire sclk_i,
	input wire csb_n_i,
	input wire sdi_i,
	// Answer word for the next frame
	input wire tx_load_i,
	input wire [15:0] tx_word_i,
	// Received frame
	output reg frame_done_o,
	output reg frame_ok_o,
	output reg [15:0] rx_word_o,
	// Serial output pin
	output wire sdo_o,
	output reg sdo_oe_o
);

	reg sclk_q;
	reg csb_q;
	reg [4:0] bit_cnt;
	reg [15:0] tx_sh;
	wire sclk_rise;
	wire sclk_fall;

	// Edges only count while selected
	assign sclk_rise = sclk_i & ~sclk_q & ~csb_n_i;
	assign sclk_fall = ~sclk_i & sclk_q & ~csb_n_i;
	assign sdo_o = tx_sh[15];

	// Sample on rising clock, shift out on falling clock
	always @(posedge clk_i) begin
		if (rst_i) begin
			sclk_q <= 1'b0;
			csb_q <= 1'b1;
			bit_cnt <= 5'h00;
			tx_sh <= 16'h0000;
			rx_word_o <= 16'h0000;
			frame_done_o <= 1'b0;
			frame_ok_o <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else begin
			sclk_q <= sclk_i;
			csb_q <= csb_n_i;
			sdo_oe_o <= ~csb_n_i;
			frame_done_o <= csb_n_i & ~csb_q;
			frame_ok_o <= (bit_cnt == `SCRB_FRAME_BITS);
			if (~csb_n_i & csb_q) begin
				bit_cnt <= 5'h00;
			end else if (sclk_rise) begin
				rx_word_o <= {rx_word_o[14:0], sdi_i};
				if (bit_cnt != 5'h1F) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
			end
			// Load only happens between frames
			if (tx_load_i) begin
				tx_sh <= tx_word_i;
			end else if (sclk_fall) begin
				tx_sh <= {tx_sh[14:0], 1'b0};
			end
		end
	end

endmodule

/* File: scrb_top.v */
// Stepper driver control register bank with serial slave access
//
// Contract
// - direction polarity bit set inverts the direction pin sense.
// - hold equals NOT(run/hold pin XOR run/hold polarity bit).
// - software step bit acts like a push on the step input.
// - bridge enable bit turns the H-bridges on; clear keeps them off.
// - four-bit stall threshold; zero disables stall detection.
// - hold current nibble used in hold, run nibble while running.
// - enhanced back-EMF bit switches enhanced measurement on or off.
// - with diagnostics enabled, bridge enable rising starts diagnostics.
// - two-bit slope field goes to the output stage.
// - sleep bit written one places device in sleep.
// - stall time-out exceeded between step periods triggers back-EMF sample.
// - measurement and stall detection only while speed <= threshold.
// - upper nibble gives level one, lower nibble level two.
// - bank select bit forces address upper nibble to one or zero.
// - gain bit zero means 0.5, one means 0.25.
// - back-EMF result interrupt only when its enable bit is set.
// - each under-voltage condition has its own interrupt enable bit.
// - boost bit activates current boost and reads back its status.
// - two-bit field in alternate bank selects open-coil detect time.
// - keep-driving bit flags open coil only while drivers active.
// - high-impedance bit, without keep-driving, drops bridge enable on open coil.
// - every access is a 16-bit transfer; device is always slave.
// - write happens only for address in upper nibble; data copied (boost register keeps only bits 4:0, rest cleared).
// - read uses lower nibble address; data byte is ignored.
`include "scrb_consts.vh"

module scrb_top (
	// Clock and reset
	input wire REF_CLK_I,
	input wire RST_I,
	// Serial port pins
	input wire SCLK_I,
	input wire CSB_N_I,
	input wire SDI_I,
	output wire SDO_O,
	output wire SDO_OE_O,
	// Motion pins
	input wire DIR_I,
	input wire RUN_HOLD_INPUT_I,
	input wire STEP_ADVANCE_INPUT_I,
	// On-chip status from same clock domain
	input wire [7:0] SPEED_I,
	input wire OPEN_COIL_I,
	input wire BACKEMF_RESULT_I,
	input wire [4:0] UNDERVOLT_I,
	// Motion controls
	output reg DIRECTION_O,
	output reg HOLD_O,
	output reg STEP_ADVANCE_O,
	output wire BRIDGE_ENABLE_O,
	output reg DIAG_START_O,
	output reg [3:0] CURRENT_LEVEL_O,
	output wire [2:0] STEP_RESOLUTION_O,
	// Stall and back-EMF
	output wire [3:0] STALL_THRESHOLD_O,
	output reg STALL_DETECT_EN_O,
	output reg BACKEMF_MEASURE_EN_O,
	output reg BACKEMF_SAMPLE_O,
	output wire ENHANCED_BACKEMF_ENABLE_O,
	output wire BACKEMF_GAIN_SELECT_O,
	// Supply, output stage and power
	output wire [1:0] SLEW_SELECT_O,
	output wire SLEEP_REQUEST_O,
	output wire [3:0] UNDERVOLTAGE_LEVEL_ONE_O,
	output wire [3:0] UNDERVOLTAGE_LEVEL_TWO_O,
	output reg IRQ_O,
	// Alternate bank controls
	output wire CURRENT_BOOST_O,
	output wire [1:0] OPEN_COIL_DETECT_TIME_O,
	output reg OPEN_COIL_FLAG_O
);

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam [31:0] TICK_CYCLES = `SCRB_TICK_NS / `SCRB_CLK_NS;
	localparam [31:0] TICK_LAST_W = TICK_CYCLES - 32'd1;
	localparam [7:0] TICK_LAST = TICK_LAST_W[7:0];

	// ----------------------------------------------------------------
	// Register storage and internal signals
	// ----------------------------------------------------------------
	reg [7:0] polarity_enable_stall_ctrl;
	reg [7:0] coil_current_levels;
	reg [7:0] drive_mode_ctrl;
	reg [7:0] stall_timeout;
	reg [7:0] speed_threshold;
	reg [7:0] undervoltage_levels;
	reg [7:0] bank_gain_irq_enable;
	reg [7:0] boost_open_coil_ctrl;

	wire [5:0] pins_s;
	wire sclk_s;
	wire csb_n_s;
	wire sdi_s;
	wire dir_s;
	wire run_hold_s;
	wire step_in_s;

	wire frame_done;
	wire frame_ok;
	wire [15:0] rx_word;
	reg resp_pend;
	reg [4:0] resp_hi;
	reg [4:0] resp_lo;
	wire [15:0] tx_word;

	wire bank_select;
	wire [4:0] addr_hi;
	wire [4:0] addr_lo;
	wire [7:0] wr_data;
	wire wr_en;
	wire open_coil_off;
	wire keep_driving;
	wire meas_en;

	reg step_in_q;
	reg sw_step;
	reg moten_q;
	reg [7:0] tick_cnt;
	reg tick;
	reg [7:0] cur_period;
	reg [7:0] prev_period;
	reg sampled;
	wire [8:0] period_limit;

	// ----------------------------------------------------------------
	// Address decode helpers
	// ----------------------------------------------------------------

	// Control registers occupy nibbles 1 to 7 in both banks
	function is_ctrl;
		input [4:0] addr;
		begin
			is_ctrl = (addr[3:0] != 4'h0) && (addr[3] == 1'b0);
		end
	endfunction

	// Readback of a control register, zero elsewhere
	function [7:0] ctrl_read;
		input [4:0] addr;
		begin
			case (addr)
				`SCRB_ADDR_STALL: ctrl_read = stall_timeout;
				`SCRB_ADDR_BOOST: ctrl_read = boost_open_coil_ctrl;
				default: begin
					case (addr[3:0])
						4'h1: ctrl_read = polarity_enable_stall_ctrl;
						4'h2: ctrl_read = coil_current_levels;
						4'h3: ctrl_read = drive_mode_ctrl;
						4'h5: ctrl_read = speed_threshold;
						4'h6: ctrl_read = undervoltage_levels;
						4'h7: ctrl_read = bank_gain_irq_enable;
						default: ctrl_read = 8'h00;
					endcase
				end
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisation and serial slave
	// ----------------------------------------------------------------

	// Every pin passes two flops before use
	scrb_sync #(
		.W(6),
		.RST_VAL(6'h02)
	) u_sync (
		.clk_i(REF_CLK_I),
		.rst_i(RST_I),
		.async_i({STEP_ADVANCE_INPUT_I, RUN_HOLD_INPUT_I, DIR_I,
			SDI_I, CSB_N_I, SCLK_I}),
		.sync_o(pins_s)
	);

	assign sclk_s = pins_s[0];
	assign csb_n_s = pins_s[1];
	assign sdi_s = pins_s[2];
	assign dir_s = pins_s[3];
	assign run_hold_s = pins_s[4];
	assign step_in_s = pins_s[5];

	scrb_spi u_spi (
		.clk_i(REF_CLK_I),
		.rst_i(RST_I),
		.sclk_i(sclk_s),
		.csb_n_i(csb_n_s),
		.sdi_i(sdi_s),
		.tx_load_i(resp_pend),
		.tx_word_i(tx_word),
		.frame_done_o(frame_done),
		.frame_ok_o(frame_ok),
		.rx_word_o(rx_word),
		.sdo_o(SDO_O),
		.sdo_oe_o(SDO_OE_O)
	);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------

	// bank bit goes in front of each 4-bit address nibble
	assign bank_select = bank_gain_irq_enable[`SCRB_BANK_BIT];
	assign addr_hi = {bank_select, rx_word[15:12]};
	assign addr_lo = {bank_select, rx_word[11:8]};
	assign wr_data = rx_word[7:0];
	// write only from the upper nibble
	assign wr_en = frame_done & frame_ok & is_ctrl(addr_hi);

	// answer built from the latched addresses
	assign tx_word = {ctrl_read(resp_hi), ctrl_read(resp_lo)};

	// Answer is built one cycle late so it shows the new contents
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			resp_pend <= 1'b0;
			resp_hi <= 5'h00;
			resp_lo <= 5'h00;
		end else begin
			resp_pend <= frame_done & frame_ok;
			if (frame_done & frame_ok) begin
				resp_hi <= addr_hi;
				resp_lo <= addr_lo;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	assign keep_driving = boost_open_coil_ctrl[`SCRB_KEEP_BIT];
	// open coil with high-impedance policy drops the bridges
	assign open_coil_off = OPEN_COIL_I & ~keep_driving &
		boost_open_coil_ctrl[`SCRB_HIZ_BIT];

	// Host writes; the open-coil cut-out wins for safety
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			polarity_enable_stall_ctrl <= `SCRB_RST_POL;
			coil_current_levels <= `SCRB_RST_COIL;
			drive_mode_ctrl <= `SCRB_RST_MODE;
			stall_timeout <= `SCRB_RST_STALL;
			speed_threshold <= `SCRB_RST_SPEED;
			undervoltage_levels <= `SCRB_RST_UVLVL;
			bank_gain_irq_enable <= `SCRB_RST_BANK;
			boost_open_coil_ctrl <= `SCRB_RST_BOOST;
		end else begin
			if (wr_en) begin
				case (addr_hi)
					`SCRB_ADDR_STALL: stall_timeout <= wr_data;
					`SCRB_ADDR_BOOST:
						boost_open_coil_ctrl <= wr_data & `SCRB_BOOST_MASK;
					default: begin
						case (addr_hi[3:0])
							4'h1: polarity_enable_stall_ctrl <= wr_data;
							4'h2: coil_current_levels <= wr_data;
							4'h3: drive_mode_ctrl <= wr_data;
							4'h5: speed_threshold <= wr_data;
							4'h6: undervoltage_levels <= wr_data;
							4'h7: bank_gain_irq_enable <= wr_data;
							default: speed_threshold <= speed_threshold;
						endcase
					end
				endcase
			end
			if (open_coil_off) begin
				polarity_enable_stall_ctrl[`SCRB_MOTEN_BIT] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Direct field outputs
	// ----------------------------------------------------------------
	// bridges follow the enable bit
	assign BRIDGE_ENABLE_O = polarity_enable_stall_ctrl[`SCRB_MOTEN_BIT];
	// threshold handed to the stall detector
	assign STALL_THRESHOLD_O = polarity_enable_stall_ctrl[3:0];
	assign ENHANCED_BACKEMF_ENABLE_O = drive_mode_ctrl[`SCRB_ENH_BIT];
	assign SLEW_SELECT_O = drive_mode_ctrl[5:4];
	assign SLEEP_REQUEST_O = drive_mode_ctrl[`SCRB_SLEEP_BIT];
	assign STEP_RESOLUTION_O = drive_mode_ctrl[2:0];
	assign UNDERVOLTAGE_LEVEL_ONE_O = undervoltage_levels[7:4];
	assign UNDERVOLTAGE_LEVEL_TWO_O = undervoltage_levels[3:0];
	// zero selects 0.5, one selects 0.25
	assign BACKEMF_GAIN_SELECT_O = bank_gain_irq_enable[`SCRB_GAIN_BIT];
	// boost drives and reads back from the same bit
	assign CURRENT_BOOST_O = boost_open_coil_ctrl[`SCRB_BOOST_BIT];
	// detection time to the open-coil detector
	assign OPEN_COIL_DETECT_TIME_O = boost_open_coil_ctrl[3:2];

	// ----------------------------------------------------------------
	// Motion logic
	// ----------------------------------------------------------------

	// Software step fires once per write carrying a one
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			sw_step <= 1'b0;
		end else begin
			sw_step <= wr_en && (addr_hi[3:0] == 4'h1) &&
				wr_data[`SCRB_STEP_BIT];
		end
	end

	// Pin polarity, current selection, step and diagnostics
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			DIRECTION_O <= 1'b0;
			HOLD_O <= 1'b1;
			STEP_ADVANCE_O <= 1'b0;
			step_in_q <= 1'b0;
			moten_q <= 1'b0;
			DIAG_START_O <= 1'b0;
			CURRENT_LEVEL_O <= 4'h0;
		end else begin
			DIRECTION_O <= dir_s ^ polarity_enable_stall_ctrl[`SCRB_DINV_BIT];
			// hold from pin and polarity bit
			HOLD_O <= ~(run_hold_s ^
				polarity_enable_stall_ctrl[`SCRB_RHBP_BIT]);
			step_in_q <= step_in_s;
			// pin edge or software step advances
			STEP_ADVANCE_O <= (step_in_s & ~step_in_q) | sw_step;
			moten_q <= polarity_enable_stall_ctrl[`SCRB_MOTEN_BIT];
			// diagnostics on bridge enable rising edge
			DIAG_START_O <= drive_mode_ctrl[`SCRB_DIAG_BIT] &
				polarity_enable_stall_ctrl[`SCRB_MOTEN_BIT] & ~moten_q;
			if (HOLD_O) begin
				CURRENT_LEVEL_O <= coil_current_levels[7:4];
			end else begin
				CURRENT_LEVEL_O <= coil_current_levels[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Stall supervision
	// ----------------------------------------------------------------

	assign meas_en = (SPEED_I <= speed_threshold);
	assign period_limit = {1'b0, prev_period} + {1'b0, stall_timeout};

	// Time base; a tick per microsecond keeps the counters small
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			tick_cnt <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == TICK_LAST);
			if (tick_cnt == TICK_LAST) begin
				tick_cnt <= 8'h00;
			end else begin
				tick_cnt <= tick_cnt + 8'h01;
			end
		end
	end

	// Step period measurement, saturating at full scale
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			cur_period <= 8'h00;
			prev_period <= 8'h00;
			sampled <= 1'b0;
			BACKEMF_SAMPLE_O <= 1'b0;
		end else begin
			BACKEMF_SAMPLE_O <= 1'b0;
			if (STEP_ADVANCE_O) begin
				prev_period <= cur_period;
				cur_period <= 8'h00;
				sampled <= 1'b0;
			end else begin
				if (tick && cur_period != 8'hFF) begin
					cur_period <= cur_period + 8'h01;
				end
				// one sample once the time-out is passed
				if (({1'b0, cur_period} > period_limit) && !sampled &&
					meas_en) begin
					BACKEMF_SAMPLE_O <= 1'b1;
					sampled <= 1'b1;
				end
			end
		end
	end

	// Measurement and detection enables
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			STALL_DETECT_EN_O <= 1'b0;
			BACKEMF_MEASURE_EN_O <= 1'b0;
		end else begin
			STALL_DETECT_EN_O <= meas_en &
				(polarity_enable_stall_ctrl[3:0] != 4'h0);
			BACKEMF_MEASURE_EN_O <= meas_en;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt gating and open-coil flag
	// ----------------------------------------------------------------
	always @(posedge REF_CLK_I) begin
		if (RST_I) begin
			IRQ_O <= 1'b0;
			OPEN_COIL_FLAG_O <= 1'b0;
		end else begin
			IRQ_O <= |({BACKEMF_RESULT_I, UNDERVOLT_I} &
				bank_gain_irq_enable[5:0]);
			// keep-driving flags only while bridges on
			OPEN_COIL_FLAG_O <= OPEN_COIL_I & (~keep_driving |
				polarity_enable_stall_ctrl[`SCRB_MOTEN_BIT]);
		end
	end

endmodule

/* File: scrb_master.sv */
// Serial host model driving 16-bit frames into the register bank
module scrb_master (
	// Serial pins toward the bank
	output logic sclk_o,
	output logic csb_n_o,
	output logic sdi_o,
	// Answer pins from the bank
	input wire logic sdo_i,
	input wire logic sdo_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// Half period of the serial clock, raised to act as a slow host
	int hp = 32;

	// Clock stands low and select high between frames
	initial begin
		sclk_o = 1'b0;
		csb_n_o = 1'b1;
		sdi_o = 1'b0;
	end

	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] r);
		r = 16'h0000;
		csb_n_o = 1'b0;
		#40;
		// MSB first, data set while clock low, answer taken on rise
		for (int i = 15; i > 15 - n; i--) begin
			sdi_o = w[i];
			#hp sclk_o = 1'b1;
			r = {r[14:0], sdo_oe_i ? sdo_i : ~sdo_i};
			#hp sclk_o = 1'b0;
		end
		#hp csb_n_o = 1'b1;
		// Released data line no longer shows the last bit
		sdi_o = ~sdi_o;
		#100;
	endtask
endmodule

/* File: scrb_top_sva.sv */
// Port-level assertions for the stepper control register bank
module scrb_chk (
	// Clock and reset
	input wire REF_CLK_I,
	input wire RST_I,
	// Watched inputs
	input wire CSB_N_I,
	input wire OPEN_COIL_I,
	input wire BACKEMF_RESULT_I,
	input wire [4:0] UNDERVOLT_I,
	// Watched outputs
	input wire SDO_OE_O,
	input wire STEP_ADVANCE_O,
	input wire BRIDGE_ENABLE_O,
	input wire DIAG_START_O,
	input wire [3:0] STALL_THRESHOLD_O,
	input wire STALL_DETECT_EN_O,
	input wire BACKEMF_MEASURE_EN_O,
	input wire BACKEMF_SAMPLE_O,
	input wire IRQ_O,
	input wire OPEN_COIL_FLAG_O
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	oe_on_a: assert property ($fell(CSB_N_I) |-> ##[2:4] SDO_OE_O)
		else $error("data driver not enabled after select");
	oe_off_a: assert property ($rose(CSB_N_I) |-> ##[3:5] !SDO_OE_O)
		else $error("data driver still on after deselect");
	stall_gate_a: assert property (STALL_DETECT_EN_O ==
		(BACKEMF_MEASURE_EN_O && $past(STALL_THRESHOLD_O) != 4'h0))
		else $error("stall enable not gated by threshold");
	irq_quiet_a: assert property (IRQ_O |->
		$past(BACKEMF_RESULT_I) || $past(UNDERVOLT_I) != 5'h00)
		else $error("interrupt without a source");
	diag_edge_a: assert property (DIAG_START_O |->
		$past(BRIDGE_ENABLE_O) && !$past(BRIDGE_ENABLE_O, 2) ##1 !DIAG_START_O)
		else $error("diagnostic start without bridge rise");
	open_flag_a: assert property (OPEN_COIL_FLAG_O |-> $past(OPEN_COIL_I))
		else $error("open coil flag without detection");
	sample_gate_a: assert property (
		BACKEMF_SAMPLE_O |-> BACKEMF_MEASURE_EN_O ##1 !BACKEMF_SAMPLE_O)
		else $error("back-EMF sample above speed threshold");
	step_pulse_a: assert property (STEP_ADVANCE_O |=> !STEP_ADVANCE_O)
		else $error("step pulse longer than one cycle");
endmodule

/* File: scrb_top_tb.sv */
// Self-checking bench for the stepper control register bank
`include "scrb_consts.vh"

module scrb_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, dir = 0, run_hold = 0, stp = 0, oc = 0;
	logic [7:0] speed = 8'h00;
	logic [5:0] src = 6'h00;
	wire sclk, csb_n, sdi, sdo, oe, direction, hold, step_o, bridge, diag;
	wire sten, bmen, bsmp, enh, gain, sleep, irq, boost, ocf;
	wire [3:0] cur, sthr, uv1, uv2;
	wire [2:0] sres;
	wire [1:0] slew, odt;
	int err_total = 0, comparisons = 0, steps = 0, samples = 0, diags = 0;

	// Clock at 200 MHz
	always #2.5 clk = ~clk;

	scrb_master m (.sclk_o(sclk), .csb_n_o(csb_n), .sdi_o(sdi), .sdo_i(sdo),
		.sdo_oe_i(oe));

	scrb_top dut (.REF_CLK_I(clk), .RST_I(rst), .SCLK_I(sclk),
		.CSB_N_I(csb_n), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(oe),
		.DIR_I(dir), .RUN_HOLD_INPUT_I(run_hold), .STEP_ADVANCE_INPUT_I(stp),
		.SPEED_I(speed), .OPEN_COIL_I(oc), .BACKEMF_RESULT_I(src[5]),
		.UNDERVOLT_I(src[4:0]), .DIRECTION_O(direction), .HOLD_O(hold),
		.STEP_ADVANCE_O(step_o), .BRIDGE_ENABLE_O(bridge),
		.DIAG_START_O(diag), .CURRENT_LEVEL_O(cur), .STEP_RESOLUTION_O(sres),
		.STALL_THRESHOLD_O(sthr), .STALL_DETECT_EN_O(sten),
		.BACKEMF_MEASURE_EN_O(bmen), .BACKEMF_SAMPLE_O(bsmp),
		.ENHANCED_BACKEMF_ENABLE_O(enh), .BACKEMF_GAIN_SELECT_O(gain),
		.SLEW_SELECT_O(slew), .SLEEP_REQUEST_O(sleep),
		.UNDERVOLTAGE_LEVEL_ONE_O(uv1), .UNDERVOLTAGE_LEVEL_TWO_O(uv2),
		.IRQ_O(irq), .CURRENT_BOOST_O(boost),
		.OPEN_COIL_DETECT_TIME_O(odt), .OPEN_COIL_FLAG_O(ocf));

	// Pulse counters for step, back-EMF sample and diagnostic start outputs
	always @(posedge clk) begin
		if (step_o === 1'b1) steps++;
		if (bsmp === 1'b1) samples++;
		if (diag === 1'b1) diags++;
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Write puts the address in the upper nibble
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [15:0] r;
		m.xfer({a, 4'h0, d}, 16, r);
	endtask

	// Read by lower nibble; answer arrives in the following frame
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		logic [15:0] r;
		m.xfer({4'h0, a, 8'h00}, 16, r);
		m.xfer(16'h0000, 16, r);
		chk(r, {8'h00, e});
	endtask

	task automatic pulse(input int gap);
		wt(1);
		stp = 1;
		wt(8);
		stp = 0;
		wt(gap);
	endtask

	// Watchdog well beyond the expected run of some 120 us
	initial begin
		#400000;
		err_total++;
		conclude();
	end

	// Main sequence
	initial begin
		logic [15:0] r;
		logic [7:0] rv [1:7] = '{`SCRB_RST_POL, `SCRB_RST_COIL, `SCRB_RST_MODE,
			`SCRB_RST_STALL, `SCRB_RST_SPEED, `SCRB_RST_UVLVL, `SCRB_RST_BANK};
		logic [7:0] wv [1:7] = '{8'h0B, 8'hA5, 8'hFB, 8'h3C, 8'h40, 8'h96, 8'h69};
		wt(5);
		rst = 0;
		wt(4);
		m.xfer(16'h0000, 16, r);
		chk(r, 16'h0000);
		for (int a = 1; a < 8; a++) rd(a[3:0], rv[a]);
		wr(4'h7, 8'h80);
		rd(4'h4, `SCRB_RST_BOOST);
		wr(4'h7, 8'h00);
		$display("reset values done");
		for (int a = 1; a < 8; a++) begin
			wr(a[3:0], wv[a]);
			rd(a[3:0], wv[a]);
		end
		chk({4'h0, sthr, uv1, uv2}, 16'h0B96);
		chk({slew, sleep, enh, gain, sres}, 8'hFB);
		m.xfer({4'h2, 4'h1, 8'h5A}, 16, r);
		m.xfer(16'h0000, 16, r);
		chk(r, 16'h5A0B);
		m.xfer({4'h0, 4'h6, 8'hFF}, 16, r);
		m.xfer(16'h0000, 16, r);
		chk(r, 16'h0096);
		m.xfer({4'h6, 4'h0, 8'h11}, 15, r);
		rd(4'h6, 8'h96);
		$display("access test done");
		wt(1);
		dir = 1;
		run_hold = 1;
		wt(8);
		chk({direction, hold, cur}, 6'h2A);
		wr(4'h1, 8'hCB);
		wt(4);
		chk({direction, hold, cur}, 6'h15);
		steps = 0;
		pulse(10);
		wr(4'h1, 8'h2B);
		wt(10);
		chk(16'(steps), 16'h0002);
		$display("motion test done");
		wr(4'h4, 8'h01);
		pulse(592);
		pulse(592);
		samples = 0;
		pulse(1992);
		chk(16'(samples), 16'h0001);
		speed = 8'h41;
		wt(2);
		chk({bmen, sten}, 2'b00);
		samples = 0;
		pulse(592);
		pulse(1992);
		chk(16'(samples), 16'h0000);
		speed = 8'h40;
		wt(2);
		chk({bmen, sten}, 2'b11);
		wr(4'h1, 8'h20);
		wt(2);
		chk({bmen, sten}, 2'b10);
		wr(4'h3, 8'h40);
		wr(4'h1, 8'h1B);
		wt(2);
		chk({bridge, sleep, enh}, 3'b100);
		chk(16'(diags), 16'h0001);
		$display("stall test done");
		for (int i = 0; i < 6; i++) begin
			wr(4'h7, 8'h01 << i);
			wt(1);
			src = 6'h01 << i;
			wt(3);
			chk(irq, 1'b1);
			src = ~(6'h01 << i);
			wt(3);
			chk(irq, 1'b0);
			src = 6'h00;
		end
		$display("interrupt test done");
		wr(4'h7, 8'h80);
		wr(4'h4, 8'hFF);
		chk({boost, odt}, 3'b111);
		rd(4'h4, 8'h1F);
		wr(4'h4, 8'h02);
		wt(1);
		oc = 1;
		wt(4);
		chk({ocf, bridge}, 2'b11);
		oc = 0;
		wr(4'h4, 8'h01);
		wt(1);
		oc = 1;
		wt(4);
		oc = 0;
		chk(bridge, 1'b0);
		wr(4'h4, 8'h03);
		wt(1);
		oc = 1;
		wt(4);
		oc = 0;
		chk({ocf, bridge}, 2'b00);
		wr(4'h7, 8'h00);
		rd(4'h4, 8'h01);
		rd(4'h1, 8'h0B);
		$display("bank test done");
		wt(1);
		rst = 1;
		wt(5);
		rst = 0;
		wt(4);
		m.xfer(16'h0000, 16, r);
		chk(r, 16'h0000);
		rd(4'h3, `SCRB_RST_MODE);
		$display("second reset done");
		conclude();
	end
endmodule

bind scrb_top scrb_chk chk_i (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
	.CSB_N_I(CSB_N_I), .OPEN_COIL_I(OPEN_COIL_I),
	.BACKEMF_RESULT_I(BACKEMF_RESULT_I), .UNDERVOLT_I(UNDERVOLT_I),
	.SDO_OE_O(SDO_OE_O), .STEP_ADVANCE_O(STEP_ADVANCE_O),
	.BRIDGE_ENABLE_O(BRIDGE_ENABLE_O), .DIAG_START_O(DIAG_START_O),
	.STALL_THRESHOLD_O(STALL_THRESHOLD_O),
	.STALL_DETECT_EN_O(STALL_DETECT_EN_O),
	.BACKEMF_MEASURE_EN_O(BACKEMF_MEASURE_EN_O),
	.BACKEMF_SAMPLE_O(BACKEMF_SAMPLE_O), .IRQ_O(IRQ_O),
	.OPEN_COIL_FLAG_O(OPEN_COIL_FLAG_O));
